// ### rtl/spe_pkg.sv
package spe_pkg;

   // ==========================================================
   // clock divider
   // ==========================================================
   localparam int              DIV_W      = 7;
   localparam logic [DIV_W-1:0] DIV_ONE   = 7'h01;
   localparam logic [DIV_W-1:0] DIV_BY_2  = 7'h02;
   localparam logic [DIV_W-1:0] DIV_BY_4  = 7'h04;
   localparam logic [DIV_W-1:0] DIV_BY_6  = 7'h06;
   localparam logic [DIV_W-1:0] DIV_BY_12 = 7'h0c;
   localparam logic [DIV_W-1:0] DIV_BY_24 = 7'h18;
   localparam logic [DIV_W-1:0] DIV_BY_48 = 7'h30;
   localparam logic [DIV_W-1:0] DIV_BY_96 = 7'h60;

   localparam logic [2:0] RATE_115200 = 3'h0;
   localparam logic [2:0] RATE_57600  = 3'h1;
   localparam logic [2:0] RATE_19200  = 3'h2;
   localparam logic [2:0] RATE_9600   = 3'h3;
   localparam logic [2:0] RATE_38400  = 3'h4;
   localparam logic [2:0] RATE_4800   = 3'h5;
   localparam logic [2:0] RATE_2400   = 3'h6;

   // code 3'h7 is not defined; it falls back to the fastest rate
   function automatic logic [DIV_W-1:0] rate_divisor(input logic [2:0] code);
      case (code)
         RATE_115200: rate_divisor = DIV_BY_2;
         RATE_57600:  rate_divisor = DIV_BY_4;
         RATE_19200:  rate_divisor = DIV_BY_12;
         RATE_9600:   rate_divisor = DIV_BY_24;
         RATE_38400:  rate_divisor = DIV_BY_6;
         RATE_4800:   rate_divisor = DIV_BY_48;
         RATE_2400:   rate_divisor = DIV_BY_96;
         default:     rate_divisor = DIV_BY_2;
      endcase
   endfunction

   // ==========================================================
   // symbol timing, in oversampling ticks or crystal cycles
   // ==========================================================
   localparam logic [3:0] BIT_TICKS_M1 = 4'hf;
   localparam logic [4:0] BIT_TICKS    = 5'h10;
   localparam logic [3:0] ENC_DELAY    = 4'h7;
   localparam logic [3:0] ENC_LAST     = 4'h9;
   localparam logic [2:0] MONO_CYCLES  = 3'h6;

   // ==========================================================
   // pins and registers
   // ==========================================================
   localparam int         PIN_N    = 7;
   localparam int         PIN_TXD  = 0;
   localparam int         PIN_ORX  = 1;
   localparam int         PIN_RATE = 2;
   localparam int         PIN_PD   = 5;
   localparam int         PIN_STY  = 6;
   localparam logic [6:0] PIN_IDLE = 7'h03;

   localparam logic [7:0] ADDR_CTRL     = 8'h00;
   localparam logic [7:0] ADDR_STATUS   = 8'h04;
   localparam logic [7:0] ADDR_TX_COUNT = 8'h08;
   localparam logic [7:0] ADDR_RX_COUNT = 8'h0c;

   localparam int CTRL_SOFT_PD = 0;
   localparam int CTRL_CLEAR   = 1;
   localparam int ST_RATE      = 0;
   localparam int ST_PD        = 3;
   localparam int ST_STYLE     = 4;
   localparam int ST_TX_BUSY   = 5;
   localparam int ST_RX_BUSY   = 6;

   typedef enum logic {ENC_IDLE, ENC_BIT} spe_enc_state_type;

endpackage

// ### rtl/spe_div_if.sv
`timescale 1ns/10ps
`default_nettype none
interface spe_div_if;
   logic [2:0] rate_code;
   logic       run;
   logic       tick;
   logic       phase;
   modport divider (input rate_code, input run, output tick, output phase);
   modport user    (output rate_code, output run, input tick, input phase);
endinterface
`default_nettype wire

// ### rtl/spe_clock_div.sv
`timescale 1ns/10ps
`default_nettype none
module spe_clock_div (
   input wire logic  clock,
   input wire logic  reset_n,
   spe_div_if.divider div
);
   logic [spe_pkg::DIV_W-1:0] count_reg;
   logic [spe_pkg::DIV_W-1:0] divisor;

   always_comb begin
      divisor = spe_pkg::rate_divisor(div.rate_code);
   end

   // a rate change mid-period may leave the count above the new end,
   // so the wrap compares with >= rather than ==
   always_ff @(posedge clock) begin
      if (!reset_n || !div.run) begin
         count_reg <= '0;
         div.tick  <= 1'b0;
         div.phase <= 1'b0;
      end else begin
         if (count_reg >= divisor - spe_pkg::DIV_ONE) begin
            count_reg <= '0;
            div.tick  <= 1'b1;
         end else begin
            count_reg <= count_reg + spe_pkg::DIV_ONE;
            div.tick  <= 1'b0;
         end
         div.phase <= (count_reg < (divisor >> 1));
      end
   end

   // ==========================================================
   // checks
   // ==========================================================
   logic [spe_pkg::DIV_W-1:0] gap_reg;
   logic                      gap_ok_reg;
   logic [2:0]                rate_prev_reg;

   always_ff @(posedge clock) begin
      rate_prev_reg <= div.rate_code;
      if (!reset_n || !div.run || rate_prev_reg != div.rate_code) begin
         gap_reg    <= spe_pkg::DIV_ONE;
         gap_ok_reg <= 1'b0;
      end else if (div.tick) begin
         gap_reg    <= spe_pkg::DIV_ONE;
         gap_ok_reg <= 1'b1;
      end else begin
         gap_reg    <= gap_reg + spe_pkg::DIV_ONE;
      end
   end

   chk_tick_period: assert property (
      @(posedge clock) disable iff (!reset_n)
      div.tick && gap_ok_reg && div.run && rate_prev_reg == div.rate_code
      |-> gap_reg == divisor)
      else $error("oversampling tick period differs from rate divisor");

   chk_rate_fallback: assert property (
      @(posedge clock) disable iff (!reset_n)
      div.rate_code == 3'h7 |-> divisor == spe_pkg::DIV_BY_2)
      else $error("undefined rate code does not divide by two");

endmodule
`default_nettype wire

// ### rtl/spe_codec.sv
`timescale 1ns/10ps
`default_nettype none
module spe_codec #(
   parameter int COUNT_W = 16
) (
   input  wire logic        clock,
   input  wire logic        reset_n,
   input  wire logic        uart_tx_in,
   output logic             uart_rx_out,
   input  wire logic        optical_rx_in,
   output logic             optical_tx_out,
   output logic             oversample_clock,
   input  wire logic        rate_code_bit2,
   input  wire logic        rate_code_bit1,
   input  wire logic        rate_code_bit0,
   input  wire logic        power_down_in,
   input  wire logic        pulse_style_sel,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_write,
   input  wire logic        reg_read,
   output logic [31:0]      reg_rdata
);
   if (COUNT_W < 1 || COUNT_W > 32) begin : g_bad_width
      $error("COUNT_W must lie between 1 and 32");
   end

   // ==========================================================
   // pin synchronisers: a change counts once stages 2 and 3 agree
   // ==========================================================
   logic [spe_pkg::PIN_N-1:0] pin_raw;
   logic [spe_pkg::PIN_N-1:0] sync1_reg;
   logic [spe_pkg::PIN_N-1:0] sync2_reg;
   logic [spe_pkg::PIN_N-1:0] sync3_reg;
   logic [spe_pkg::PIN_N-1:0] pin_reg;

   assign pin_raw = {pulse_style_sel, power_down_in, rate_code_bit2,
                     rate_code_bit1, rate_code_bit0, optical_rx_in,
                     uart_tx_in};

   for (genvar i = 0; i < spe_pkg::PIN_N; i++) begin : g_sync
      always_ff @(posedge clock) begin
         if (!reset_n) begin
            sync1_reg[i] <= spe_pkg::PIN_IDLE[i];
            sync2_reg[i] <= spe_pkg::PIN_IDLE[i];
            sync3_reg[i] <= spe_pkg::PIN_IDLE[i];
            pin_reg[i]   <= spe_pkg::PIN_IDLE[i];
         end else begin
            sync1_reg[i] <= pin_raw[i];
            sync2_reg[i] <= sync1_reg[i];
            sync3_reg[i] <= sync2_reg[i];
            if (sync2_reg[i] == sync3_reg[i]) begin
               pin_reg[i] <= sync3_reg[i];
            end
         end
      end
   end

   logic       txd;
   logic       orx;
   logic [2:0] rate_code;
   logic       style_mono;
   logic       soft_pd_reg;
   logic       pd_active_reg;

   assign txd        = pin_reg[spe_pkg::PIN_TXD];
   assign orx        = pin_reg[spe_pkg::PIN_ORX];
   assign rate_code  = pin_reg[spe_pkg::PIN_RATE +: 3];
   assign style_mono = pin_reg[spe_pkg::PIN_STY];

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         pd_active_reg <= 1'b0;
      end else begin
         pd_active_reg <= pin_reg[spe_pkg::PIN_PD] | soft_pd_reg;
      end
   end

   // ==========================================================
   // oversampling clock
   // ==========================================================
   spe_div_if div_bus ();
   logic      tick;

   assign div_bus.rate_code = rate_code;
   assign div_bus.run       = !pd_active_reg;
   assign tick              = div_bus.tick;

   spe_clock_div u_div (
      .clock   (clock),
      .reset_n (reset_n),
      .div     (div_bus.divider)
   );

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         oversample_clock <= 1'b0;
      end else begin
         oversample_clock <= div_bus.phase;
      end
   end

   // ==========================================================
   // encoder
   // ==========================================================
   spe_pkg::spe_enc_state_type enc_state_reg;
   logic [3:0]                 enc_cnt_reg;
   logic [3:0]                 enc_cnt_next;
   logic                       enc_prev_reg;
   logic                       enc_mod_reg;

   assign enc_cnt_next = enc_cnt_reg + 4'h1;

   // an idle-low transmit line (broken) is not silent: it counts as high
   // after reset or power-down, starts a bit, then pulses every bit
   always_ff @(posedge clock) begin
      if (!reset_n || pd_active_reg) begin
         enc_state_reg <= spe_pkg::ENC_IDLE;
         enc_cnt_reg   <= '0;
         enc_prev_reg  <= 1'b1;
         enc_mod_reg   <= 1'b0;
      end else if (tick) begin
         enc_prev_reg <= txd;
         case (enc_state_reg)
            spe_pkg::ENC_IDLE: begin
               enc_mod_reg <= 1'b0;
               enc_cnt_reg <= '0;
               if (enc_prev_reg && !txd) begin
                  enc_state_reg <= spe_pkg::ENC_BIT;
               end
            end
            spe_pkg::ENC_BIT: begin
               if (enc_cnt_reg == spe_pkg::BIT_TICKS_M1) begin
                  enc_cnt_reg <= '0;
                  enc_mod_reg <= 1'b0;
                  if (txd) begin
                     enc_state_reg <= spe_pkg::ENC_IDLE;
                  end
               end else begin
                  enc_cnt_reg <= enc_cnt_next;
                  enc_mod_reg <= enc_cnt_next >= spe_pkg::ENC_DELAY &&
                                 enc_cnt_next <= spe_pkg::ENC_LAST;
               end
            end
            default: begin
               enc_state_reg <= spe_pkg::ENC_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // monoshot and transmit output
   // ==========================================================
   logic       mod_prev_reg;
   logic [2:0] mono_cnt_reg;

   always_ff @(posedge clock) begin
      if (!reset_n || pd_active_reg) begin
         mod_prev_reg <= 1'b0;
         mono_cnt_reg <= '0;
      end else begin
         mod_prev_reg <= enc_mod_reg;
         if (enc_mod_reg && !mod_prev_reg) begin
            mono_cnt_reg <= spe_pkg::MONO_CYCLES;
         end else if (mono_cnt_reg != 3'h0) begin
            mono_cnt_reg <= mono_cnt_reg - 3'h1;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!reset_n || pd_active_reg) begin
         optical_tx_out <= 1'b0;
      end else if (style_mono) begin
         optical_tx_out <= mono_cnt_reg != 3'h0;
      end else begin
         optical_tx_out <= enc_mod_reg;
      end
   end

   // ==========================================================
   // decoder
   // ==========================================================
   // a receive pulse can be shorter than a slow tick, so the edge is
   // caught at crystal rate and held until the next tick
   logic       orx_prev_reg;
   logic       orx_fall;
   logic       rx_pend_reg;
   logic [4:0] dec_cnt_reg;

   assign orx_fall = orx_prev_reg && !orx;

   always_ff @(posedge clock) begin
      if (!reset_n || pd_active_reg) begin
         orx_prev_reg <= 1'b1;
         rx_pend_reg  <= 1'b0;
         dec_cnt_reg  <= '0;
         uart_rx_out  <= 1'b1;
      end else begin
         orx_prev_reg <= orx;
         if (orx_fall) begin
            rx_pend_reg <= 1'b1;
         end else if (tick) begin
            rx_pend_reg <= 1'b0;
         end
         if (tick && rx_pend_reg) begin
            dec_cnt_reg <= spe_pkg::BIT_TICKS;
         end else if (tick && dec_cnt_reg != 5'h00) begin
            dec_cnt_reg <= dec_cnt_reg - 5'h01;
         end
         uart_rx_out <= dec_cnt_reg == 5'h00;
      end
   end

   // ==========================================================
   // registers
   // ==========================================================
   logic [COUNT_W-1:0] tx_count_reg;
   logic [COUNT_W-1:0] rx_count_reg;
   logic               clear_req;

   assign clear_req = reg_write && reg_addr == spe_pkg::ADDR_CTRL &&
                      reg_wdata[spe_pkg::CTRL_CLEAR];

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         soft_pd_reg <= 1'b0;
      end else if (reg_write && reg_addr == spe_pkg::ADDR_CTRL) begin
         soft_pd_reg <= reg_wdata[spe_pkg::CTRL_SOFT_PD];
      end
   end

   // a pulse in the clearing cycle is still counted
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         tx_count_reg <= '0;
         rx_count_reg <= '0;
      end else begin
         if (enc_mod_reg && !mod_prev_reg) begin
            tx_count_reg <= clear_req ? COUNT_W'(1) : tx_count_reg + 1'b1;
         end else if (clear_req) begin
            tx_count_reg <= '0;
         end
         if (orx_fall && !pd_active_reg) begin
            rx_count_reg <= clear_req ? COUNT_W'(1) : rx_count_reg + 1'b1;
         end else if (clear_req) begin
            rx_count_reg <= '0;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!reset_n || !reg_read) begin
         reg_rdata <= '0;
      end else begin
         case (reg_addr)
            spe_pkg::ADDR_CTRL: begin
               reg_rdata <= {31'h0000_0000, soft_pd_reg};
            end
            spe_pkg::ADDR_STATUS: begin
               reg_rdata <= {25'h000_0000, dec_cnt_reg != 5'h00,
                             enc_state_reg == spe_pkg::ENC_BIT,
                             style_mono, pd_active_reg, rate_code};
            end
            spe_pkg::ADDR_TX_COUNT: begin
               reg_rdata <= 32'(tx_count_reg);
            end
            spe_pkg::ADDR_RX_COUNT: begin
               reg_rdata <= 32'(rx_count_reg);
            end
            default: begin
               reg_rdata <= '0;
            end
         endcase
      end
   end

   // ==========================================================
   // checks
   // ==========================================================
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!reset_n);

   logic [5:0] rise_gap_reg;
   logic [5:0] low_ticks_reg;

   always_ff @(posedge clock) begin
      if (!reset_n || pd_active_reg) begin
         rise_gap_reg  <= 6'h3f;
         low_ticks_reg <= '0;
      end else begin
         if (enc_mod_reg && !mod_prev_reg) begin
            rise_gap_reg <= '0;
         end else if (tick && rise_gap_reg != 6'h3f) begin
            rise_gap_reg <= rise_gap_reg + 6'h01;
         end
         if (uart_rx_out) begin
            low_ticks_reg <= '0;
         end else if (tick && low_ticks_reg != 6'h3f) begin
            low_ticks_reg <= low_ticks_reg + 6'h01;
         end
      end
   end

   chk_mark_silent: assert property (
      enc_state_reg == spe_pkg::ENC_IDLE |=> !enc_mod_reg)
      else $error("encoder pulse outside a space bit");

   chk_pulse_place: assert property (
      tick && enc_state_reg == spe_pkg::ENC_BIT &&
      enc_cnt_reg == spe_pkg::ENC_DELAY - 4'h1 && !pd_active_reg
      |-> !enc_mod_reg ##1 enc_mod_reg && enc_cnt_reg == spe_pkg::ENC_DELAY)
      else $error("encoder pulse does not start on the seventh tick");

   chk_pulse_width: assert property (
      $fell(enc_mod_reg) && !pd_active_reg && !$past(pd_active_reg) |->
      enc_cnt_reg == spe_pkg::ENC_LAST + 4'h1)
      else $error("encoder pulse not three ticks wide");

   chk_space_period: assert property (
      enc_mod_reg && !mod_prev_reg && rise_gap_reg != 6'h3f |->
      rise_gap_reg == 6'h10 || rise_gap_reg >= 6'h1e)
      else $error("encoder pulses not one bit apart");

   chk_rx_edge: assert property (
      orx_fall && !pd_active_reg && !soft_pd_reg && !pin_reg[spe_pkg::PIN_PD]
      |-> ##[1:100] !uart_rx_out)
      else $error("received edge not decoded to a space");

   chk_rx_stretch: assert property (
      $rose(uart_rx_out) && !pd_active_reg && !$past(pd_active_reg)
      |-> $past(low_ticks_reg) >= 6'h10)
      else $error("receive space shorter than one bit");

   chk_mono_width: assert property (
      $rose(optical_tx_out) && style_mono && $stable(style_mono) &&
      !pin_reg[spe_pkg::PIN_PD] && !soft_pd_reg
      |-> optical_tx_out[*6] ##1 !optical_tx_out)
      else $error("monoshot pulse not six crystal cycles");

   chk_pd_quiet: assert property (
      pd_active_reg |=> !optical_tx_out && uart_rx_out)
      else $error("traffic while powered down");

   chk_style_sel: assert property (
      !style_mono && !pd_active_reg && $stable(style_mono) |=>
      optical_tx_out == $past(enc_mod_reg))
      else $error("3/16 style output does not follow encoder");

   cov_tx_pulse:    cover property ($rose(optical_tx_out));
   cov_back_to_back: cover property (
      enc_mod_reg && !mod_prev_reg && rise_gap_reg == 6'h10);
   cov_mono:        cover property ($rose(optical_tx_out) && style_mono);
   cov_rx_space:    cover property ($rose(uart_rx_out) && !pd_active_reg);

endmodule
`default_nettype wire

// ### verification/spe_far_model.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// uart transmitter and optical receiver seen from the far side
// ==========================================================
module spe_far_model (
   input  wire logic clock,
   output var logic  uart_tx_in,
   output var logic  optical_rx_in
);
   initial begin
      uart_tx_in    = 1'b1;
      optical_rx_in = 1'b1;
   end

   // lsb first, each bit held one bit time; line idles high after
   task automatic send_bits(input logic [7:0] bits, input int n,
                            input int bit_clocks);
      for (int i = 0; i < n; i++) begin
         @(posedge clock) uart_tx_in <= bits[i];
         repeat (bit_clocks - 1) @(posedge clock);
      end
      @(posedge clock) uart_tx_in <= 1'b1;
   endtask

   // transceiver output is active low; falling edge marks a pulse
   task automatic optical_pulse(input int clocks);
      @(posedge clock) optical_rx_in <= 1'b0;
      repeat (clocks) @(posedge clock);
      optical_rx_in <= 1'b1;
   endtask
endmodule
`default_nettype wire

// ### verification/sir_pulse_encoder_decoder_bench.sv
`timescale 1ns/10ps
`default_nettype none
module sir_pulse_encoder_decoder_bench;
   logic        clock = 1'b0;
   logic        reset_n = 1'b0;
   logic        uart_tx_in;
   logic        uart_rx_out;
   logic        optical_rx_in;
   logic        optical_tx_out;
   logic        oversample_clock;
   logic [2:0]  rate = 3'h0;
   logic        power_down_in = 1'b0;
   logic        pulse_style_sel = 1'b0;
   logic [7:0]  reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0000_0000;
   logic        reg_write = 1'b0;
   logic        reg_read = 1'b0;
   logic [31:0] reg_rdata;
   int mismatches = 0;
   int checks_done = 0;
   int cyc = 0, tx_rises = 0, tx_at = 0, tx_gap = 0, tx_width = 0;
   int rx_falls = 0, rx_at = 0, rx_width = 0, osc_at = 0, osc_period = 0;
   logic tx_q = 1'b0, rx_q = 1'b1, osc_q = 1'b0;
   int divs [8] = '{2, 4, 12, 24, 6, 48, 96, 2};

   always #5 clock = ~clock;

   spe_far_model i_far (
      .clock         (clock),
      .uart_tx_in    (uart_tx_in),
      .optical_rx_in (optical_rx_in)
   );

   spe_codec i_dut (
      .clock            (clock),
      .reset_n          (reset_n),
      .uart_tx_in       (uart_tx_in),
      .uart_rx_out      (uart_rx_out),
      .optical_rx_in    (optical_rx_in),
      .optical_tx_out   (optical_tx_out),
      .oversample_clock (oversample_clock),
      .rate_code_bit2   (rate[2]),
      .rate_code_bit1   (rate[1]),
      .rate_code_bit0   (rate[0]),
      .power_down_in    (power_down_in),
      .pulse_style_sel  (pulse_style_sel),
      .reg_addr         (reg_addr),
      .reg_wdata        (reg_wdata),
      .reg_write        (reg_write),
      .reg_read         (reg_read),
      .reg_rdata        (reg_rdata)
   );

   // ==========================================================
   // edge monitor: outputs are registers, so edge-time values
   // are the settled values of the previous cycle
   // ==========================================================
   always @(posedge clock) begin
      cyc = cyc + 1;
      if (optical_tx_out === 1'b1 && tx_q === 1'b0) begin
         tx_gap = cyc - tx_at;
         tx_at = cyc;
         tx_rises++;
      end
      if (optical_tx_out === 1'b0 && tx_q === 1'b1) tx_width = cyc - tx_at;
      if (uart_rx_out === 1'b0 && rx_q === 1'b1) begin
         rx_at = cyc;
         rx_falls++;
      end
      if (uart_rx_out === 1'b1 && rx_q === 1'b0) rx_width = cyc - rx_at;
      if (oversample_clock === 1'b1 && osc_q === 1'b0) begin
         osc_period = cyc - osc_at;
         osc_at = cyc;
      end
      tx_q = optical_tx_out;
      rx_q = uart_rx_out;
      osc_q = oversample_clock;
   end

   // ==========================================================
   // shared tasks
   // ==========================================================
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clock) reg_write <= 1'b0;
   endtask

   task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clock) reg_read <= 1'b0;
      #1 d = reg_rdata;
   endtask

   task automatic conclude;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // ==========================================================
   // scenarios
   // ==========================================================
   task automatic test_reset;
      check(optical_tx_out, 1'b0);
      check(uart_rx_out, 1'b1);
      check(reg_rdata, 32'h0000_0000);
   endtask

   task automatic test_rates;
      for (int c = 0; c < 8; c++) begin
         @(posedge clock) rate <= c[2:0];
         repeat (250) @(posedge clock);
         check(osc_period, divs[c]);
      end
      @(posedge clock) rate <= 3'h0;
      repeat (20) @(posedge clock);
   endtask

   task automatic test_tx_spaces;
      int n0;
      int t0;
      int first;
      logic [31:0] d;
      reg_wr(spe_pkg::ADDR_CTRL, 32'h0000_0002);
      n0 = tx_rises;
      t0 = cyc;
      // two spaces back to back, then a mark
      i_far.send_bits(8'h04, 3, 32);
      repeat (40) @(posedge clock);
      first = tx_at - tx_gap - t0;
      check(tx_rises - n0, 2);
      check(tx_gap, 32);
      check(tx_width, 6);
      check(first >= 14 && first <= 24, 1'b1);
      reg_rd(spe_pkg::ADDR_TX_COUNT, d);
      check(d, 32'h0000_0002);
   endtask

   task automatic test_monoshot;
      int n0;
      @(posedge clock) pulse_style_sel <= 1'b1;
      foreach (divs[c]) begin
         if (c == 0 || c == 4) begin
            @(posedge clock) rate <= c[2:0];
            repeat (250) @(posedge clock);
            n0 = tx_rises;
            i_far.send_bits(8'h00, 1, 16 * divs[c]);
            repeat (16 * divs[c]) @(posedge clock);
            check(tx_rises - n0, 1);
            check(tx_width, 6);
         end
      end
      @(posedge clock);
      pulse_style_sel <= 1'b0;
      rate <= 3'h0;
      repeat (20) @(posedge clock);
   endtask

   task automatic test_rx;
      logic [31:0] d;
      for (int c = 0; c < 5; c += 4) begin
         @(posedge clock) rate <= c[2:0];
         repeat (250) @(posedge clock);
         i_far.optical_pulse(4);
         repeat (16 * divs[c] + 30) @(posedge clock);
         check(rx_width, 16 * divs[c]);
      end
      @(posedge clock) rate <= 3'h0;
      repeat (20) @(posedge clock);
      reg_rd(spe_pkg::ADDR_RX_COUNT, d);
      check(d, 32'h0000_0002);
   endtask

   task automatic test_power_down;
      int t0;
      int r0;
      logic [31:0] d;
      @(posedge clock) power_down_in <= 1'b1;
      repeat (10) @(posedge clock);
      t0 = tx_rises;
      r0 = rx_falls;
      i_far.send_bits(8'h00, 1, 32);
      i_far.optical_pulse(4);
      repeat (60) @(posedge clock);
      check(tx_rises - t0, 0);
      check(rx_falls - r0, 0);
      reg_rd(spe_pkg::ADDR_STATUS, d);
      check(d[spe_pkg::ST_PD], 1'b1);
      @(posedge clock) power_down_in <= 1'b0;
      repeat (10) @(posedge clock);
   endtask

   task automatic test_registers;
      logic [31:0] d;
      @(posedge clock);
      rate <= spe_pkg::RATE_9600;
      pulse_style_sel <= 1'b1;
      repeat (10) @(posedge clock);
      reg_rd(spe_pkg::ADDR_STATUS, d);
      check(d, 32'h0000_0013);
      reg_wr(spe_pkg::ADDR_CTRL, 32'h0000_0003);
      reg_rd(spe_pkg::ADDR_CTRL, d);
      check(d, 32'h0000_0001);
      reg_rd(spe_pkg::ADDR_STATUS, d);
      check(d[spe_pkg::ST_PD], 1'b1);
      reg_wr(spe_pkg::ADDR_CTRL, 32'h0000_0000);
      reg_wr(8'h40, 32'hffff_ffff);
      reg_rd(8'h40, d);
      check(d, 32'h0000_0000);
      @(posedge clock);
      rate <= 3'h0;
      pulse_style_sel <= 1'b0;
      repeat (10) @(posedge clock);
   endtask

   initial begin
      repeat (2) @(posedge clock);
      reset_n <= 1'b1;
      #1 test_reset;
      repeat (10) @(posedge clock);
      test_rates;
      test_tx_spaces;
      test_monoshot;
      test_rx;
      test_power_down;
      test_registers;
      conclude;
   end

   initial begin
      #500000;
      mismatches++;
      conclude;
   end
endmodule
`default_nettype wire
